// >>> usb_ep_irq_pkg.sv
// shared constants and carrier types for the endpoint interrupt flag logic
`default_nettype none

package usb_ep_irq_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int         NUM_EP       = 5;
  localparam logic [2:0] EP_LIMIT_SEL = 3'h5;  // first select value with no endpoint
  localparam int         COUNT_W      = 7;

  // ****************************************************************
  // special function register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_EP_SELECT   = 8'hc2;
  localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'hc3;
  localparam logic [7:0] ADDR_IRQ_REQUEST = 8'hc4;

  // ****************************************************************
  // bit positions, shared by enable and request registers
  // ****************************************************************
  localparam int BIT_SUCCESS   = 7;
  localparam int BIT_FAILURE   = 6;
  localparam int BIT_LEN_ERR   = 5;
  localparam int BIT_RESERVED  = 4;
  localparam int BIT_UNAVAIL   = 3;
  localparam int BIT_MISUSE    = 2;
  localparam int BIT_CPU_DONE  = 1;
  localparam int BIT_BUS_DONE  = 0;

  // ****************************************************************
  // reset values and masks
  // ****************************************************************
  localparam logic [7:0] ENABLE_RESET  = 8'h00;
  localparam logic [7:0] REQ0_RESET    = 8'h11;
  localparam logic [7:0] REQN_RESET    = 8'h10;
  localparam logic [2:0] SELECT_RESET  = 3'h0;
  localparam logic [7:0] FLAG_MASK     = 8'hef;  // all bits but the reserved one
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // ****************************************************************
  // carriers
  // ****************************************************************
  // cpu access on the special function register port
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  // bus device controller status for one endpoint
  typedef struct packed {
    logic xfer_end;         // pulse: a bus transaction finished
    logic xfer_ok;          // qualifies xfer_end: handshake succeeded
    logic mem_req;          // pulse: controller needs buffer memory
    logic byte_strobe;      // pulse: one byte moved on the bus side
    logic page_swap;        // pulse: dual buffer page swapped
    logic bus_buffer_full;  // level
  } bus_side_s;

  // cpu buffer side status for one endpoint
  typedef struct packed {
    logic               cpu_rd;              // pulse: cpu reads buffer memory
    logic               cpu_wr;              // pulse: cpu writes buffer memory
    logic               cpu_buf_empty;       // level
    logic               cpu_buf_full;        // level
    logic               endpoint_direction;  // 1: device to host
    logic               buffer_restart;      // pulse: endpoint buffer cleared
    logic [COUNT_W-1:0] programmed_max_count;
    logic [COUNT_W-1:0] received_byte_count;
  } cpu_side_s;

endpackage : usb_ep_irq_pkg

`default_nettype wire

// >>> endpoint_event_detect.sv
// event detection for one endpoint: turns buffer and bus activity into flag set pulses
`default_nettype none

module endpoint_event_detect
  import usb_ep_irq_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  input  wire bus_side_s bus_in,
  input  wire cpu_side_s cpu_in,
  output logic [7:0]     events_out,
  output logic           refuse_out
);

  logic [COUNT_W-1:0] cpu_cnt;
  logic [COUNT_W-1:0] bus_cnt;
  logic               lock;
  logic               misuse;
  logic               cpu_take;
  logic               cpu_last;
  logic               bus_last;
  logic [COUNT_W-1:0] cpu_limit;
  logic [COUNT_W-1:0] len_cnt;

  // cpu side: host read fills the transmit buffer, host write drains the receive one
  assign cpu_limit = cpu_in.endpoint_direction ? cpu_in.programmed_max_count
                                               : cpu_in.received_byte_count;
  assign misuse   = (cpu_in.cpu_rd & cpu_in.cpu_buf_empty)
                  | (cpu_in.cpu_wr & cpu_in.cpu_buf_full)
                  | (cpu_in.cpu_wr & ~cpu_in.endpoint_direction)
                  | (lock & (cpu_in.cpu_rd | cpu_in.cpu_wr));
  assign cpu_take = ~misuse & (cpu_in.endpoint_direction ? cpu_in.cpu_wr : cpu_in.cpu_rd);
  assign cpu_last = cpu_take & (cpu_cnt + 7'h01 == cpu_limit);
  assign bus_last = bus_in.byte_strobe & (bus_cnt + 7'h01 == cpu_in.received_byte_count);

  // cpu byte counter
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_cnt <= 7'h00;
    end else if (cpu_in.buffer_restart | bus_in.page_swap | cpu_last) begin
      cpu_cnt <= 7'h00;
    end else if (cpu_take) begin
      cpu_cnt <= cpu_cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock <= 1'b0;
    end else if (cpu_in.buffer_restart | bus_in.page_swap) begin
      lock <= 1'b0;
    end else if (cpu_last) begin
      lock <= 1'b1;
    end
  end

  // bus byte counter, restarted at each transaction end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_cnt <= 7'h00;
    end else if (cpu_in.buffer_restart | bus_in.xfer_end | bus_last) begin
      bus_cnt <= 7'h00;
    end else if (bus_in.byte_strobe) begin
      bus_cnt <= bus_cnt + 7'h01;
    end
  end

  // read length
  // host read length, kept past bus done so an exact packet compares equal
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      len_cnt <= 7'h00;
    end else if (cpu_in.buffer_restart | bus_in.xfer_end) begin
      len_cnt <= 7'h00;
    end else if (bus_in.byte_strobe) begin
      len_cnt <= len_cnt + 7'h01;
    end
  end

  assign refuse_out = lock;

  // set pulses in request register layout
  always_comb begin
    events_out = READ_ZERO;
    events_out[BIT_SUCCESS]  = bus_in.xfer_end & bus_in.xfer_ok;
    events_out[BIT_FAILURE]  = bus_in.xfer_end & ~bus_in.xfer_ok;
    events_out[BIT_LEN_ERR]  = bus_in.xfer_end & cpu_in.endpoint_direction
                             & (len_cnt != cpu_in.programmed_max_count);
    events_out[BIT_UNAVAIL]  = bus_in.mem_req & (cpu_in.endpoint_direction
                             ? ~bus_in.bus_buffer_full : bus_in.bus_buffer_full);
    events_out[BIT_MISUSE]   = misuse;
    events_out[BIT_CPU_DONE] = cpu_last | bus_in.page_swap;
    events_out[BIT_BUS_DONE] = bus_last | bus_in.page_swap;
  end

endmodule : endpoint_event_detect

`default_nettype wire

// >>> usb_endpoint_interrupt_flags.sv
// endpoint interrupt request flags, enables and cpu register access for five endpoints
`default_nettype none

module usb_endpoint_interrupt_flags
  import usb_ep_irq_pkg::*;
(
  input  wire logic                   ref_clk_in,
  input  wire logic                   resetn_in,
  input  wire sfr_req_s               sfr_in,
  input  wire bus_side_s [NUM_EP-1:0] bus_side_in,
  input  wire cpu_side_s [NUM_EP-1:0] cpu_side_in,
  input  wire logic [NUM_EP-1:0]      endpoint_global_irq_in,
  input  wire logic                   usb_endpoint_irq_master_en_in,
  input  wire logic                   master_irq_enable_in,
  output logic [7:0]                  sfr_rdata_out,
  output logic [NUM_EP-1:0]           ep_irq_out,
  output logic                        cpu_irq_out,
  output logic [NUM_EP-1:0]           cpu_refuse_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic              rst_meta;
  logic              rst_n;
  logic [2:0]        endpoint_select;
  logic              sel_valid;
  logic              wr_select;
  logic              wr_enable;
  logic              rd_request;
  logic [7:0]        endpoint_irq_enable  [NUM_EP];
  logic [7:0]        endpoint_irq_request [NUM_EP];
  logic [7:0]        ep_events            [NUM_EP];
  logic [NUM_EP-1:0] ep_refuse;
  logic [NUM_EP-1:0] pending;
  logic [7:0]        next_rdata;
  logic              next_cpu_irq;

  // ****************************************************************
  // reset release
  // ****************************************************************

  // two-stage release of the asynchronous reset
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************************
  // register access decode
  // ****************************************************************

  // selected endpoint exists only for select values 0 to 4
  assign sel_valid  = (endpoint_select < EP_LIMIT_SEL);
  assign wr_select  = sfr_in.wr & (sfr_in.addr == ADDR_EP_SELECT);
  assign wr_enable  = sfr_in.wr & (sfr_in.addr == ADDR_IRQ_ENABLE) & sel_valid;
  assign rd_request = sfr_in.rd & (sfr_in.addr == ADDR_IRQ_REQUEST) & sel_valid;

  // endpoint select register, low three bits kept
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      endpoint_select <= SELECT_RESET;
    end else if (wr_select) begin
      endpoint_select <= sfr_in.wdata[2:0];
    end
  end

  // ****************************************************************
  // per endpoint logic
  // ****************************************************************

  for (genvar n = 0; n < NUM_EP; n++) begin : g_ep
    localparam logic [2:0] EP_ID   = 3'(n);
    localparam logic [7:0] REQ_RST = (n == 0) ? REQ0_RESET : REQN_RESET;

    logic hit_enable;
    logic hit_request;

    assign hit_enable  = wr_enable  & (endpoint_select == EP_ID);
    assign hit_request = rd_request & (endpoint_select == EP_ID);

    // event sources of this endpoint
    endpoint_event_detect u_detect (
      .clk_in     (ref_clk_in),
      .rst_n_in   (rst_n),
      .bus_in     (bus_side_in[n]),
      .cpu_in     (cpu_side_in[n]),
      .events_out (ep_events[n]),
      .refuse_out (ep_refuse[n])
    );

    // enable register, reserved bit held at zero
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        endpoint_irq_enable[n] <= ENABLE_RESET;
      end else if (hit_enable) begin
        endpoint_irq_enable[n] <= sfr_in.wdata & FLAG_MASK;
      end
    end

    // request flags: cleared by a read, set by events, set wins
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        endpoint_irq_request[n] <= REQ_RST;
      end else if (hit_request) begin
        endpoint_irq_request[n] <= (endpoint_irq_request[n] & ~FLAG_MASK)
                                 | (ep_events[n] & FLAG_MASK);
      end else begin
        endpoint_irq_request[n] <= endpoint_irq_request[n]
                                 | (ep_events[n] & FLAG_MASK);
      end
    end

    // each enabled flag contributes to the endpoint request
    // every source but the reserved bit
    assign pending[n] = |(endpoint_irq_request[n] & endpoint_irq_enable[n] & FLAG_MASK);
  end

  // ****************************************************************
  // interrupt outputs
  // ****************************************************************

  assign next_cpu_irq = (|(pending & endpoint_global_irq_in))
                      & usb_endpoint_irq_master_en_in
                      & master_irq_enable_in;

  // registered endpoint requests and combined cpu request
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ep_irq_out  <= '0;
      cpu_irq_out <= 1'b0;
    end else begin
      ep_irq_out  <= pending;
      cpu_irq_out <= next_cpu_irq;
    end
  end

  // registered copy of the cpu access lockout per endpoint
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cpu_refuse_out <= '0;
    end else begin
      cpu_refuse_out <= ep_refuse;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************

  // read mux; unmapped addresses and absent endpoints read zero
  always_comb begin
    next_rdata = READ_ZERO;
    case (sfr_in.addr)
      ADDR_EP_SELECT: begin
        next_rdata = {5'h00, endpoint_select};
      end
      ADDR_IRQ_ENABLE: begin
        if (sel_valid) begin
          next_rdata = endpoint_irq_enable[endpoint_select];
        end
      end
      ADDR_IRQ_REQUEST: begin
        if (sel_valid) begin
          next_rdata = endpoint_irq_request[endpoint_select];
        end
      end
      default: begin
        next_rdata = READ_ZERO;
      end
    endcase
  end

  // read data captured before the clear lands, held until next read
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_out <= READ_ZERO;
    end else if (sfr_in.rd) begin
      sfr_rdata_out <= next_rdata;
    end
  end

endmodule : usb_endpoint_interrupt_flags

`default_nettype wire

// >>> usb_host_model.sv
// behavioural usb host side that drives bus controller status for each endpoint
`default_nettype none

module usb_host_model
  import usb_ep_irq_pkg::*;
(
  input  wire logic                   clk_in,
  output var  bus_side_s [NUM_EP-1:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // nothing on the bus until the bench asks
  initial bus_out = '0;

  // one transaction outcome after an optional wait, held for exactly one cycle
  task automatic send(input int ep, input bus_side_s v, input int gap);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    bus_out[ep] <= v;
    @(posedge clk_in);
    bus_out[ep] <= '0;
  endtask : send
endmodule : usb_host_model

`default_nettype wire

// >>> usb_endpoint_interrupt_flags_assertions.sv
// port level checks for the endpoint interrupt flag block
`default_nettype none

module usb_endpoint_interrupt_flags_assertions
  import usb_ep_irq_pkg::*;
(
  input wire logic                   ref_clk_in,
  input wire logic                   resetn_in,
  input wire sfr_req_s               sfr_in,
  input wire bus_side_s [NUM_EP-1:0] bus_side_in,
  input wire cpu_side_s [NUM_EP-1:0] cpu_side_in,
  input wire logic [NUM_EP-1:0]      endpoint_global_irq_in,
  input wire logic                   usb_endpoint_irq_master_en_in,
  input wire logic                   master_irq_enable_in,
  input wire logic [7:0]             sfr_rdata_out,
  input wire logic [NUM_EP-1:0]      ep_irq_out,
  input wire logic                   cpu_irq_out
);
  logic [2:0] sel;
  logic [7:0] en0;

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  // ****************************************************************
  // helper copies of select and endpoint 0 enable
  // ****************************************************************
  // shadow registers fed from the cpu writes seen at the port
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sel <= SELECT_RESET;
      en0 <= ENABLE_RESET;
    end else if (sfr_in.wr) begin
      if (sfr_in.addr == ADDR_EP_SELECT) sel <= sfr_in.wdata[2:0];
      if (sfr_in.addr == ADDR_IRQ_ENABLE && sel == 3'h0) en0 <= sfr_in.wdata & FLAG_MASK;
    end
  end

  sequence quiet0;
    !(bus_side_in[0].xfer_end || bus_side_in[0].mem_req || bus_side_in[0].byte_strobe ||
      bus_side_in[0].page_swap || cpu_side_in[0].cpu_rd || cpu_side_in[0].cpu_wr);
  endsequence
  sequence clear0;
    sfr_in.rd && sfr_in.addr == ADDR_IRQ_REQUEST && sel == 3'h0;
  endsequence

  // ****************************************************************
  // assertions
  // ****************************************************************
  // four level gating
  combine_a: assert property (
    cpu_irq_out == (|(ep_irq_out & $past(endpoint_global_irq_in)) &&
      $past(usb_endpoint_irq_master_en_in) && $past(master_irq_enable_in)))
    else $error("combined request does not follow its gates");
  res_enable_a: assert property (
    sfr_in.rd && sfr_in.addr == ADDR_IRQ_ENABLE |=> !sfr_rdata_out[BIT_RESERVED])
    else $error("reserved enable bit read as one");
  res_request_a: assert property (
    sfr_in.rd && sfr_in.addr == ADDR_IRQ_REQUEST && sel < EP_LIMIT_SEL
    |=> sfr_rdata_out[BIT_RESERVED]) else $error("reserved request bit lost");
  refused_read_a: assert property (
    sfr_in.rd && (sfr_in.addr < ADDR_EP_SELECT || sfr_in.addr > ADDR_IRQ_REQUEST ||
      (sfr_in.addr != ADDR_EP_SELECT && sel >= EP_LIMIT_SEL)) |=> sfr_rdata_out == READ_ZERO)
    else $error("refused read returned data");
  select_read_a: assert property (
    sfr_in.rd && sfr_in.addr == ADDR_EP_SELECT |=> sfr_rdata_out == {5'h00, sel})
    else $error("select readback wrong");
  success_irq_a: assert property (
    bus_side_in[0].xfer_end && bus_side_in[0].xfer_ok && en0[BIT_SUCCESS]
    |-> ##[1:2] ep_irq_out[0]) else $error("success event did not raise request");
  read_clear_a: assert property (
    clear0 ##0 quiet0 ##1 quiet0 [*2] |=> !ep_irq_out[0])
    else $error("request survived a read with no new event");
  set_wins_a: assert property (
    clear0 ##0 (bus_side_in[0].xfer_end && bus_side_in[0].xfer_ok && en0[BIT_SUCCESS])
    |=> ##2 ep_irq_out[0]) else $error("event in clear cycle was lost");
  mask_a: assert property (
    (en0 == ENABLE_RESET) [*3] |=> !ep_irq_out[0])
    else $error("request raised with all sources masked");
endmodule : usb_endpoint_interrupt_flags_assertions

bind usb_endpoint_interrupt_flags usb_endpoint_interrupt_flags_assertions checks (
  .ref_clk_in, .resetn_in, .sfr_in, .bus_side_in, .cpu_side_in, .endpoint_global_irq_in,
  .usb_endpoint_irq_master_en_in, .master_irq_enable_in, .sfr_rdata_out, .ep_irq_out,
  .cpu_irq_out);

`default_nettype wire

// >>> usb_endpoint_interrupt_flags_bench.sv
// self-checking bench for the endpoint interrupt flag block
`default_nettype none

module usb_endpoint_interrupt_flags_bench
  import usb_ep_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   ref_clk_in, resetn_in;
  sfr_req_s               sfr_in;
  bus_side_s [NUM_EP-1:0] bus_side_in;
  cpu_side_s [NUM_EP-1:0] cpu_side_in;
  logic [NUM_EP-1:0]      endpoint_global_irq_in, ep_irq_out, cpu_refuse_out;
  logic                   usb_endpoint_irq_master_en_in, master_irq_enable_in, cpu_irq_out;
  logic [7:0]             sfr_rdata_out;
  int                     err_count = 0;
  int                     cmp_count = 0;
  // event table: bus status, direction, flags expected
  logic [5:0] ev_bus [8] = '{6'h30, 6'h20, 6'h30, 6'h09, 6'h00, 6'h00, 6'h04, 6'h02};
  logic [7:0] ev_exp [8] = '{8'h80, 8'h40, 8'ha0, 8'h08, 8'h04, 8'h02, 8'h01, 8'h03};
  logic [7:0] ev_dir     = 8'h24;

  usb_host_model host (.clk_in(ref_clk_in), .bus_out(bus_side_in));
  usb_endpoint_interrupt_flags dut (
    .ref_clk_in, .resetn_in, .sfr_in, .bus_side_in, .cpu_side_in, .endpoint_global_irq_in,
    .usb_endpoint_irq_master_en_in, .master_irq_enable_in, .sfr_rdata_out, .ep_irq_out,
    .cpu_irq_out, .cpu_refuse_out);

  // 250 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  // one register access, strobe held for a single cycle
  task automatic sfr(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    sfr_in <= '{r, !r, a, d};
    @(posedge ref_clk_in);
    sfr_in <= '0;
    #1;
  endtask : sfr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr(1'b1, a, 8'h00);
    chk(sfr_rdata_out, exp);
  endtask : rd

  // cpu buffer write when w is high, buffer restart otherwise
  task automatic cpu_pulse(input logic w);
    @(posedge ref_clk_in);
    cpu_side_in[0].cpu_wr <= w;
    cpu_side_in[0].buffer_restart <= !w;
    @(posedge ref_clk_in);
    cpu_side_in[0].cpu_wr <= 1'b0;
    cpu_side_in[0].buffer_restart <= 1'b0;
  endtask : cpu_pulse

  // cpu buffer read held for n cycles, optionally against an empty buffer
  task automatic cpu_read(input int n, input logic empty);
    @(posedge ref_clk_in);
    cpu_side_in[0].cpu_rd <= 1'b1;
    cpu_side_in[0].cpu_buf_empty <= empty;
    repeat (n) @(posedge ref_clk_in);
    cpu_side_in[0].cpu_rd <= 1'b0;
    cpu_side_in[0].cpu_buf_empty <= 1'b0;
  endtask : cpu_read

  task automatic fire(input int k);
    if (ev_bus[k] != 6'h00) begin
      host.send(0, bus_side_s'(ev_bus[k]), 0);
    end else begin
      cpu_pulse(1'b1);
    end
  endtask : fire

  // bounded wait for the endpoint 0 request
  task automatic wait_irq();
    #1;
    for (int i = 0; ep_irq_out[0] !== 1'b1; i++) begin
      if (i == 8) begin
        err_count++;
        summarize();
      end
      @(posedge ref_clk_in);
      #1;
    end
  endtask : wait_irq

  // watchdog against a hung run
  initial begin
    #100000;
    err_count++;
    summarize();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    resetn_in = 1'b0;
    sfr_in = '0;
    cpu_side_in = '0;
    cpu_side_in[0].programmed_max_count = 7'h01;
    cpu_side_in[0].received_byte_count = 7'h01;
    endpoint_global_irq_in = 5'h1f;
    usb_endpoint_irq_master_en_in = 1'b1;
    master_irq_enable_in = 1'b1;
    repeat (3) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    // reset values per endpoint, then refused select value 5
    for (int e = 0; e < 6; e++) begin
      sfr(1'b0, ADDR_EP_SELECT, 8'(e));
      rd(ADDR_EP_SELECT, 8'(e));
      rd(ADDR_IRQ_ENABLE, e < 5 ? ENABLE_RESET : READ_ZERO);
      rd(ADDR_IRQ_REQUEST, e == 0 ? REQ0_RESET : e < 5 ? REQN_RESET : READ_ZERO);
      rd(ADDR_IRQ_REQUEST, e < 5 ? REQN_RESET : READ_ZERO);
    end
    rd(8'hc5, READ_ZERO);
    $display("test reset values done");
    sfr(1'b0, ADDR_EP_SELECT, 8'h00);
    // each event source enabled, then masked
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk_in);
      cpu_side_in[0].endpoint_direction <= ev_dir[k];
      sfr(1'b0, ADDR_IRQ_ENABLE, ev_exp[k]);
      fire(k);
      wait_irq();
      chk(8'(cpu_irq_out), 8'h01);
      if (k == 5) chk(8'(cpu_refuse_out[0]), 8'h01);
      rd(ADDR_IRQ_REQUEST, ev_exp[k] | REQN_RESET);
      cpu_pulse(1'b0);
      sfr(1'b0, ADDR_IRQ_ENABLE, FLAG_MASK & ~ev_exp[k]);
      fire(k);
      repeat (4) @(posedge ref_clk_in);
      #1;
      chk(8'(ep_irq_out[0]), 8'h00);
      rd(ADDR_IRQ_REQUEST, ev_exp[k] | REQN_RESET);
      cpu_pulse(1'b0);
      $display("test event %0d done", k);
    end
    // each upper gate removed in turn, slow host
    sfr(1'b0, ADDR_IRQ_ENABLE, 8'h80);
    host.send(0, 6'h30, 2);
    wait_irq();
    for (int g = 0; g < 3; g++) begin
      @(posedge ref_clk_in);
      endpoint_global_irq_in[0] <= g != 0;
      usb_endpoint_irq_master_en_in <= g != 1;
      master_irq_enable_in <= g != 2;
      repeat (3) @(posedge ref_clk_in);
      #1;
      chk(8'({ep_irq_out[0], cpu_irq_out}), 8'h02);
    end
    $display("test gating done");
    // event in the clearing cycle survives
    fork
      rd(ADDR_IRQ_REQUEST, 8'h90);
      host.send(0, 6'h30, 0);
    join
    repeat (3) @(posedge ref_clk_in);
    rd(ADDR_IRQ_REQUEST, 8'h90);
    // a read clears only the selected endpoint, request writes ignored
    host.send(1, 6'h30, 0);
    host.send(2, 6'h20, 0);
    sfr(1'b0, ADDR_EP_SELECT, 8'h01);
    sfr(1'b0, ADDR_IRQ_ENABLE, 8'h80);
    @(posedge ref_clk_in);
    #1;
    chk(8'(ep_irq_out), 8'h02);
    rd(ADDR_IRQ_REQUEST, 8'h90);
    sfr(1'b0, ADDR_EP_SELECT, 8'h02);
    sfr(1'b0, ADDR_IRQ_REQUEST, 8'hff);
    rd(ADDR_IRQ_REQUEST, 8'h50);
    rd(ADDR_IRQ_REQUEST, REQN_RESET);
    $display("test clearing done");
    // exact host read length: bus done and success, no length error
    sfr(1'b0, ADDR_EP_SELECT, 8'h00);
    @(posedge ref_clk_in);
    cpu_side_in[0].endpoint_direction <= 1'b1;
    host.send(0, 6'h04, 0);
    host.send(0, 6'h30, 0);
    rd(ADDR_IRQ_REQUEST, 8'h91);
    // host write direction: counted read, a refused read, then an empty read
    @(posedge ref_clk_in);
    cpu_side_in[0].endpoint_direction <= 1'b0;
    cpu_read(2, 1'b0);
    #1;
    chk(8'(cpu_refuse_out[0]), 8'h01);
    rd(ADDR_IRQ_REQUEST, 8'h16);
    cpu_pulse(1'b0);
    cpu_read(1, 1'b1);
    #1;
    chk(8'(cpu_refuse_out[0]), 8'h00);
    rd(ADDR_IRQ_REQUEST, 8'h14);
    $display("test buffer access done");
    summarize();
  end
endmodule : usb_endpoint_interrupt_flags_bench

`default_nettype wire
